// file: rtl/run_stop_seq.sv
// Purpose: Start/stop sequencer of a motor drive with parameter registers.
// Assumes: All inputs synchronous to i_mclk; speeds in 0.01 Hz units.
// Notes:   Register bus answers reads one cycle after the read strobe.
//
// Contract
// - Source select: commanded (0) or measured (1) speed.
// - Open-loop voltage mode forces commanded speed source.
// - Stop detect time 0.00-100.00 s, default 0.50.
// - Terminal mode samples run terminal at power-up.
// - Protection 0: wait terminal release, then re-assert.
// - Protection 1: run after init if terminal asserted.
// - Below lower limit: hold limit (0) or stop (1).
// - Set frequency below lower limit while running enters sleep.
// - Wake after set frequency stays above limit delay.
// - Restart enable 1: auto run after wait time.
// - Restart wait 0.0-3600.0 s, default 1.0.
// - Start delay 0.0-600.0 s before run output.
// - Zero Hz open-loop: none, voltage, DC brake.
// - Decelerate to stop; stop at stop speed.
// - DC brake current sets braking strength.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module run_stop_seq #(
    parameter int TICK_CYC = run_stop_pkg::TICK_FINE_CYC
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_srst,
    input  wire run_stop_pkg::bus_req_s i_bus,
    output logic [15:0]                 o_rdata,
    input  wire logic                   i_init_done,
    input  wire logic                   i_term_mode,
    input  wire logic                   i_term_run,
    input  wire logic                   i_other_run,
    input  wire logic                   i_open_loop,
    input  wire logic [15:0]            i_set_freq,
    input  wire logic [15:0]            i_lower_limit,
    input  wire logic [15:0]            i_cmd_speed,
    input  wire logic [15:0]            i_meas_speed,
    input  wire logic [15:0]            i_dc_brake_current,
    output run_stop_pkg::out_ctl_s      o_ctl,
    output logic [15:0]                 o_brake_current,
    output logic                        o_stopped
);

    initial
    begin
        if (TICK_CYC < 2)
            $error("TICK_CYC must be at least 2");
    end

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
        clamp16 = (v > lim) ? lim : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Time base: fine tick every 10 ms, coarse tick every 100 ms.

    logic [31:0] div_reg;
    logic [3:0]  coarse_reg;
    wire         tick_fine   = (div_reg == 32'(TICK_CYC - 1));
    wire         coarse_wrap = (coarse_reg == run_stop_pkg::COARSE_DIV - 4'h1);
    wire         tick_coarse = tick_fine && coarse_wrap;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            div_reg    <= 32'h0;
            coarse_reg <= 4'h0;
        end
        else
        begin
            div_reg <= tick_fine ? 32'h0 : div_reg + 32'h1;
            if (tick_fine)
                coarse_reg <= coarse_wrap ? 4'h0 : coarse_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Parameter registers.

    logic [15:0] src_sel_reg;
    logic [15:0] det_time_reg;
    logic [15:0] protect_reg;
    logic [15:0] low_act_reg;
    logic [15:0] wake_dly_reg;
    logic [15:0] rst_en_reg;
    logic [15:0] rst_wait_reg;
    logic [15:0] start_dly_reg;
    logic [15:0] stop_dly_reg;
    logic [15:0] zero_sel_reg;
    logic [15:0] stop_thr_reg;
    logic [15:0] rdata_next;
    logic [15:0] status_word;

    wire wr_src   = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_SRC_SEL);
    wire wr_det   = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_DET_TIME);
    wire wr_prot  = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_PROTECT);
    wire wr_low   = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_LOW_ACT);
    wire wr_wake  = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_WAKE_DLY);
    wire wr_rsten = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_RST_EN);
    wire wr_rstw  = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_RST_WAIT);
    wire wr_start = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_START_DLY);
    wire wr_sdly  = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_STOP_DLY);
    wire wr_zero  = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_ZERO_SEL);
    wire wr_thr   = i_bus.wr && (i_bus.addr == run_stop_pkg::IDX_STOP_THR);

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            src_sel_reg   <= 16'h0;
            det_time_reg  <= run_stop_pkg::RST_DET_TIME;
            protect_reg   <= 16'h0;
            low_act_reg   <= 16'h0;
            wake_dly_reg  <= run_stop_pkg::RST_WAKE_DLY;
            rst_en_reg    <= 16'h0;
            rst_wait_reg  <= run_stop_pkg::RST_RST_WAIT;
            start_dly_reg <= run_stop_pkg::RST_START_DLY;
            stop_dly_reg  <= run_stop_pkg::RST_STOP_DLY;
            zero_sel_reg  <= 16'h0;
            stop_thr_reg  <= run_stop_pkg::RST_STOP_THR;
        end
        else
        begin
            if (wr_src)
                src_sel_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_FLAG);
            if (wr_det)
                det_time_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_DET_TIME);
            if (wr_prot)
                protect_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_FLAG);
            if (wr_low)
                low_act_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_FLAG);
            if (wr_wake)
                wake_dly_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_WAKE_DLY);
            if (wr_rsten)
                rst_en_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_FLAG);
            if (wr_rstw)
                rst_wait_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_RST_WAIT);
            if (wr_start)
                start_dly_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_START_DLY);
            if (wr_sdly)
                stop_dly_reg <= i_bus.wdata;
            if (wr_zero)
                zero_sel_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_ZERO_SEL);
            if (wr_thr)
                stop_thr_reg <= clamp16(i_bus.wdata, run_stop_pkg::MAX_STOP_THR);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read decode.

    run_stop_pkg::seq_state_e state_reg;
    run_stop_pkg::seq_state_e state_next;

    assign status_word = {9'h0, state_reg};

    always_comb
    begin
        if (i_bus.addr == run_stop_pkg::IDX_SRC_SEL)
            rdata_next = src_sel_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_DET_TIME)
            rdata_next = det_time_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_PROTECT)
            rdata_next = protect_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_LOW_ACT)
            rdata_next = low_act_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_WAKE_DLY)
            rdata_next = wake_dly_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_RST_EN)
            rdata_next = rst_en_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_RST_WAIT)
            rdata_next = rst_wait_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_START_DLY)
            rdata_next = start_dly_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_STOP_DLY)
            rdata_next = stop_dly_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_ZERO_SEL)
            rdata_next = zero_sel_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_STOP_THR)
            rdata_next = stop_thr_reg;
        else if (i_bus.addr == run_stop_pkg::IDX_STATUS)
            rdata_next = status_word;
        else
            rdata_next = 16'h0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_rdata <= 16'h0;
        else
            o_rdata <= i_bus.rd ? rdata_next : 16'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sequencing conditions and timers.

    logic        pwr_term_reg;
    logic        rst_done;
    logic        start_done;
    logic        wake_done;
    logic        det_done;
    wire         run_req     = i_term_mode ? i_term_run : i_other_run;
    wire         use_meas    = src_sel_reg[0] && !i_open_loop;
    wire [15:0]  stop_speed  = use_meas ? i_meas_speed : i_cmd_speed;
    wire         at_stop     = (stop_speed <= stop_thr_reg);
    wire         set_below   = (i_set_freq < i_lower_limit);
    wire         set_above   = (i_set_freq > i_lower_limit);
    wire         go_sleep    = set_below && low_act_reg[0];
    wire         init_start  = (state_reg == run_stop_pkg::ST_INIT) && i_init_done;
    wire         rst_arm     = init_start && rst_en_reg[0];

    tick_timer u_rst_tmr (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_run   (rst_arm),
        .i_tick  (tick_coarse),
        .i_limit (rst_wait_reg),
        .o_done  (rst_done)
    );

    tick_timer u_start_tmr (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_run   ((state_reg == run_stop_pkg::ST_START) && run_req),
        .i_tick  (tick_coarse),
        .i_limit (start_dly_reg),
        .o_done  (start_done)
    );

    tick_timer u_wake_tmr (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_run   ((state_reg == run_stop_pkg::ST_SLEEP) && set_above),
        .i_tick  (tick_coarse),
        .i_limit (wake_dly_reg),
        .o_done  (wake_done)
    );

    tick_timer u_det_tmr (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_run   ((state_reg == run_stop_pkg::ST_STOP) && at_stop),
        .i_tick  (tick_fine),
        .i_limit (det_time_reg),
        .o_done  (det_done)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Run/stop state machine.

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            run_stop_pkg::ST_INIT:
                if (rst_arm && rst_done && run_req)
                    state_next = run_stop_pkg::ST_START;
                else if (rst_arm && !rst_done)
                    state_next = run_stop_pkg::ST_INIT;
                else if (i_init_done && i_term_mode && pwr_term_reg && !protect_reg[0])
                    state_next = run_stop_pkg::ST_PROTECT;
                else if (i_init_done && i_term_mode && pwr_term_reg)
                    state_next = run_stop_pkg::ST_START;
                else if (i_init_done)
                    state_next = run_stop_pkg::ST_IDLE;
            run_stop_pkg::ST_PROTECT:
                if (!i_term_run)
                    state_next = run_stop_pkg::ST_IDLE;
            run_stop_pkg::ST_IDLE:
                if (run_req)
                    state_next = run_stop_pkg::ST_START;
            run_stop_pkg::ST_START:
                if (!run_req)
                    state_next = run_stop_pkg::ST_IDLE;
                else if (start_done)
                    state_next = run_stop_pkg::ST_RUN;
            run_stop_pkg::ST_RUN:
                if (!run_req)
                    state_next = run_stop_pkg::ST_STOP;
                else if (go_sleep)
                    state_next = run_stop_pkg::ST_SLEEP;
            run_stop_pkg::ST_STOP:
                if (run_req)
                    state_next = run_stop_pkg::ST_RUN;
                else if (det_done)
                    state_next = run_stop_pkg::ST_IDLE;
            run_stop_pkg::ST_SLEEP:
                if (!run_req)
                    state_next = run_stop_pkg::ST_IDLE;
                else if (wake_done)
                    state_next = run_stop_pkg::ST_RUN;
            default:
                state_next = run_stop_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state_reg    <= run_stop_pkg::ST_INIT;
            pwr_term_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == run_stop_pkg::ST_INIT)
                pwr_term_reg <= i_term_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Output stage controls.

    wire in_run    = (state_reg == run_stop_pkg::ST_RUN);
    wire in_stop   = (state_reg == run_stop_pkg::ST_STOP);
    wire zero_hz   = (in_run || in_stop) && i_open_loop && (i_cmd_speed == 16'h0);
    wire [1:0] zsel = zero_sel_reg[1:0];
    run_stop_pkg::out_ctl_s ctl_next;

    always_comb
    begin
        ctl_next.run_enable = in_run || in_stop;
        ctl_next.decel      = in_stop;
        ctl_next.hold_lower = in_run && set_below && !low_act_reg[0];
        ctl_next.zero_volt  = zero_hz && (zsel == run_stop_pkg::ZERO_NO_VOLT);
        ctl_next.dc_brake   = zero_hz && (zsel == run_stop_pkg::ZERO_DC_BRAKE);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_ctl           <= '0;
            o_brake_current <= 16'h0;
            o_stopped       <= 1'b0;
        end
        else
        begin
            o_ctl           <= ctl_next;
            o_brake_current <= ctl_next.dc_brake ? i_dc_brake_current : 16'h0;
            o_stopped       <= in_stop && det_done && !run_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    a_src_open_loop: assert property (@(posedge i_mclk) disable iff (i_srst)
        i_open_loop |-> stop_speed == i_cmd_speed)
        else $error("measured source used in open loop");
    a_det_default: assert property (@(posedge i_mclk) disable iff (i_srst)
        $past(i_srst) |-> det_time_reg == run_stop_pkg::RST_DET_TIME)
        else $error("detect time default wrong");
    a_protect_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        (state_reg == run_stop_pkg::ST_PROTECT) && i_term_run |=> !o_ctl.run_enable)
        else $error("runs while protected");
    a_protect_enter: assert property (@(posedge i_mclk) disable iff (i_srst)
        init_start && !rst_en_reg[0] && i_term_mode && pwr_term_reg && !protect_reg[0]
        |=> state_reg == run_stop_pkg::ST_PROTECT)
        else $error("protection not entered");
    a_auto_start: assert property (@(posedge i_mclk) disable iff (i_srst)
        init_start && !rst_en_reg[0] && i_term_mode && pwr_term_reg && protect_reg[0]
        |=> state_reg == run_stop_pkg::ST_START)
        else $error("auto start missing");
    a_low_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        in_run && set_below && !low_act_reg[0] && run_req |=> o_ctl.hold_lower)
        else $error("lower limit not held");
    a_sleep_enter: assert property (@(posedge i_mclk) disable iff (i_srst)
        in_run && run_req && go_sleep |=> state_reg == run_stop_pkg::ST_SLEEP)
        else $error("sleep not entered");
    a_start_wait: assert property (@(posedge i_mclk) disable iff (i_srst)
        (state_reg == run_stop_pkg::ST_START) && !start_done |=> !in_run)
        else $error("run before start delay");
    a_zero_brake: assert property (@(posedge i_mclk) disable iff (i_srst)
        zero_hz && zsel == run_stop_pkg::ZERO_DC_BRAKE |=> o_ctl.dc_brake && !o_ctl.zero_volt)
        else $error("zero Hz brake mode wrong");
    a_stop_done: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_stopped |-> state_reg == run_stop_pkg::ST_IDLE)
        else $error("stop flag outside idle");

    c_stop_seq: cover property (@(posedge i_mclk) disable iff (i_srst) o_stopped);
    c_wake: cover property (@(posedge i_mclk) disable iff (i_srst)
        state_reg == run_stop_pkg::ST_SLEEP ##1 in_run);
    c_protect: cover property (@(posedge i_mclk) disable iff (i_srst)
        state_reg == run_stop_pkg::ST_PROTECT ##1 state_reg == run_stop_pkg::ST_IDLE);

endmodule

// file: rtl/run_stop_pkg.sv
// Purpose: Shared constants and types for the run/stop sequencer.
// Assumes: 125 MHz clock, 16-bit parameter words.
// Notes:   Times are in the unit of each setting's last digit.
package run_stop_pkg;

    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          TICK_FINE_NS   = 10_000_000;
    localparam int          TICK_FINE_CYC  = TICK_FINE_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  COARSE_DIV     = 4'ha;

    localparam logic [3:0]  IDX_SRC_SEL    = 4'h0;
    localparam logic [3:0]  IDX_DET_TIME   = 4'h1;
    localparam logic [3:0]  IDX_PROTECT    = 4'h2;
    localparam logic [3:0]  IDX_LOW_ACT    = 4'h3;
    localparam logic [3:0]  IDX_WAKE_DLY   = 4'h4;
    localparam logic [3:0]  IDX_RST_EN     = 4'h5;
    localparam logic [3:0]  IDX_RST_WAIT   = 4'h6;
    localparam logic [3:0]  IDX_START_DLY  = 4'h7;
    localparam logic [3:0]  IDX_STOP_DLY   = 4'h8;
    localparam logic [3:0]  IDX_ZERO_SEL   = 4'h9;
    localparam logic [3:0]  IDX_STOP_THR   = 4'ha;
    localparam logic [3:0]  IDX_STATUS     = 4'hb;

    localparam logic [15:0] RST_DET_TIME   = 16'h0032;
    localparam logic [15:0] RST_WAKE_DLY   = 16'h0000;
    localparam logic [15:0] RST_RST_WAIT   = 16'h000a;
    localparam logic [15:0] RST_START_DLY  = 16'h0000;
    localparam logic [15:0] RST_STOP_DLY   = 16'h0000;
    localparam logic [15:0] RST_STOP_THR   = 16'h0032;

    localparam logic [15:0] MAX_DET_TIME   = 16'h2710;
    localparam logic [15:0] MAX_WAKE_DLY   = 16'h8ca0;
    localparam logic [15:0] MAX_RST_WAIT   = 16'h8ca0;
    localparam logic [15:0] MAX_START_DLY  = 16'h1770;
    localparam logic [15:0] MAX_STOP_THR   = 16'h2710;
    localparam logic [15:0] MAX_ZERO_SEL   = 16'h0002;
    localparam logic [15:0] MAX_FLAG       = 16'h0001;

    localparam logic [1:0]  ZERO_NO_VOLT   = 2'h0;
    localparam logic [1:0]  ZERO_VOLT      = 2'h1;
    localparam logic [1:0]  ZERO_DC_BRAKE  = 2'h2;

    typedef enum logic [6:0] {
        ST_INIT    = 7'h01,
        ST_PROTECT = 7'h02,
        ST_IDLE    = 7'h04,
        ST_START   = 7'h08,
        ST_RUN     = 7'h10,
        ST_STOP    = 7'h20,
        ST_SLEEP   = 7'h40
    } seq_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic        run_enable;
        logic        decel;
        logic        hold_lower;
        logic        zero_volt;
        logic        dc_brake;
    } out_ctl_s;

endpackage

// file: rtl/tick_timer.sv
// Purpose: Saturating tick counter that reports an elapsed setting.
// Assumes: i_tick is a one-cycle pulse of the time base.
// Notes:   Count restarts whenever i_run is low.
`timescale 1ns/10ps
module tick_timer #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_srst,
    input  wire logic         i_run,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_limit,
    output logic              o_done
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    wire          at_max = &cnt_reg;

    initial
    begin
        if (W < 2)
            $error("tick_timer width too small");
    end

    assign cnt_next = !i_run ? '0 : (i_tick && !at_max) ? cnt_reg + 1'b1 : cnt_reg;
    assign o_done   = i_run && (cnt_reg >= i_limit);

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

endmodule

// file: testbench/motor_side_model.sv
// Purpose: Run terminal and motor stage beside the sequencer.
// Assumes: Measured speed falls while the drive decelerates.
// Notes:   The terminal level follows the bench press request.
`timescale 1ns/10ps
module motor_side_model (
    input  wire logic   i_mclk,
    input  wire logic   i_press,
    input  wire logic   i_decel,
    output logic        o_term_run,
    output logic [15:0] o_meas_speed
);
    assign o_term_run = i_press;
    always_ff @(posedge i_mclk)
    begin
        if (!i_decel)
            o_meas_speed <= 16'h1000;
        else if (o_meas_speed > 16'h00ff)
            o_meas_speed <= o_meas_speed - 16'h0100;
        else
            o_meas_speed <= 16'h0000;
    end
endmodule

// file: testbench/tb_drive_run_stop_sequencer.sv
// Purpose: Self-checking bench of the run/stop sequencer.
// Assumes: Short time base so that timers finish quickly.
// Notes:   State is read back through the status register.
`timescale 1ns/10ps
module tb_drive_run_stop_sequencer;
    logic                   i_mclk = 1'b0;
    logic                   i_srst = 1'b1;
    run_stop_pkg::bus_req_s i_bus = '0;
    logic [15:0]            o_rdata;
    logic                   i_init_done = 1'b0;
    logic                   i_open_loop = 1'b0;
    logic                   i_term_mode = 1'b1;
    logic                   i_other_run = 1'b0;
    logic                   press = 1'b1;
    logic                   term_run;
    logic [15:0]            i_set_freq = 16'h0100;
    logic [15:0]            i_lower_limit = 16'h0080;
    logic [15:0]            i_cmd_speed = 16'h0000;
    logic [15:0]            meas_speed;
    run_stop_pkg::out_ctl_s o_ctl;
    logic [15:0]            o_brake_current;
    logic                   o_stopped;
    int                     fail_count = 0;
    int                     n_compared = 0;
    int                     cyc = 0;
    always #4 i_mclk = ~i_mclk;
    motor_side_model side (.i_mclk, .i_press(press), .i_decel(o_ctl.decel),
        .o_term_run(term_run), .o_meas_speed(meas_speed));
    run_stop_seq #(.TICK_CYC(2)) dut (.i_mclk, .i_srst, .i_bus, .o_rdata,
        .i_init_done, .i_term_mode, .i_term_run(term_run), .i_other_run,
        .i_open_loop, .i_set_freq, .i_lower_limit, .i_cmd_speed,
        .i_meas_speed(meas_speed), .i_dc_brake_current(16'h0123), .o_ctl,
        .o_brake_current, .o_stopped);
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_bus <= {2'b10, a, d};
        @(posedge i_mclk);
        i_bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        i_bus <= {2'b01, a, 16'h0000};
        @(posedge i_mclk);
        i_bus <= '0;
        #1 d = o_rdata;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic wst(input logic [15:0] e);
        logic [15:0] d;
        d = ~e;
        for (int k = 0; k < 300 && d !== e; k++)
            rd(4'hb, d);
        chk(d, e);
    endtask
    task automatic rst;
        @(posedge i_mclk);
        i_init_done <= 1'b0;
        i_srst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        rst();
        rc(4'h1, 16'h0032);
        rc(4'h6, 16'h000a);
        rc(4'hb, 16'h0001);
        rc(4'hc, 16'h0000);
        wr(4'h9, 16'hffff);
        rc(4'h9, 16'h0002);
    endtask
    task automatic t_protect;
        i_init_done <= 1'b1;
        wst(16'h0002);
        chk({15'h0, o_ctl.run_enable}, 16'h0000);
        press <= 1'b0;
        wst(16'h0004);
        press <= 1'b1;
        wst(16'h0010);
        chk({15'h0, o_ctl.run_enable}, 16'h0001);
    endtask
    task automatic t_sleep_wake;
        wr(4'h3, 16'h0001);
        i_set_freq <= 16'h0040;
        wst(16'h0040);
        i_set_freq <= 16'h0100;
        wst(16'h0010);
    endtask
    task automatic t_lower_hold;
        wr(4'h3, 16'h0000);
        i_set_freq <= 16'h0040;
        wst(16'h0010);
        chk({15'h0, o_ctl.hold_lower}, 16'h0001);
        i_set_freq <= 16'h0100;
    endtask
    task automatic t_zero_hz;
        i_open_loop <= 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            wr(4'h9, 16'(s));
            repeat (3) @(posedge i_mclk);
            #1 chk({14'h0, o_ctl.zero_volt, o_ctl.dc_brake},
                   (s == 0) ? 16'h0002 : (s == 2) ? 16'h0001 : 16'h0000);
            chk(o_brake_current, (s == 2) ? 16'h0123 : 16'h0000);
        end
    endtask
    task automatic t_stop_detect;
        i_cmd_speed <= 16'h1000;
        wr(4'h0, 16'h0001);
        press <= 1'b0;
        wst(16'h0020);
        chk({15'h0, o_ctl.decel}, 16'h0001);
        repeat (150) @(posedge i_mclk);
        rc(4'hb, 16'h0020);
        i_open_loop <= 1'b0;
        for (int k = 0; k < 400 && o_stopped !== 1'b1; k++)
            @(negedge i_mclk);
        chk({15'h0, o_stopped}, 16'h0001);
        rc(4'hb, 16'h0004);
    endtask
    task automatic t_auto_start;
        rst();
        press <= 1'b1;
        wr(4'h2, 16'h0001);
        i_init_done <= 1'b1;
        wst(16'h0010);
        i_cmd_speed <= 16'h0000;
        press <= 1'b0;
        wst(16'h0004);
    endtask
    task automatic t_start_delay;
        wr(4'h7, 16'h0002);
        press <= 1'b1;
        repeat (4) @(posedge i_mclk);
        rc(4'hb, 16'h0008);
        wst(16'h0010);
    endtask
    task automatic t_restart;
        rst();
        wr(4'h5, 16'h0001);
        i_init_done <= 1'b1;
        rc(4'hb, 16'h0001);
        wst(16'h0010);
    endtask
    task automatic t_other_source;
        rst();
        i_term_mode <= 1'b0;
        i_init_done <= 1'b1;
        wst(16'h0004);
        i_other_run <= 1'b1;
        wst(16'h0010);
        chk({15'h0, o_ctl.run_enable}, 16'h0001);
    endtask
    initial
    begin
        t_defaults();
        t_protect();
        t_sleep_wake();
        t_lower_hold();
        t_zero_hz();
        t_stop_detect();
        t_auto_start();
        t_start_delay();
        t_restart();
        t_other_source();
        finish_test();
    end
endmodule
